// ### rtl/pmtx_consts.svh
// Purpose: constants for the performance monitor transactional extensions
// Assumes: included by bare name
// Notes:   record offsets are byte offsets within one sample record
`ifndef PMTX_CONSTS_SVH
`define PMTX_CONSTS_SVH
`define PMTX_OFF_NEXT_IP      8'h08
`define PMTX_OFF_TRIG_IP      8'hB0
`define PMTX_OFF_ABORT_INFO   8'hB8
`define PMTX_RT_DMND_DATA     0
`define PMTX_RT_DMND_OWN      1
`define PMTX_RT_DMND_CODE     2
`define PMTX_RT_PF_DATA       4
`define PMTX_RT_PF_OWN        5
`define PMTX_RT_PF_CODE       6
`define PMTX_RT_OTHER         15
`define PMTX_RT_MASK          16'h8077
`define PMTX_SEL_MASK         64'h0000_003F_FFFF_8077
`define PMTX_EVS_IN_TX        32
`define PMTX_EVS_CP           33
`define PMTX_EVS_CP_INDEX     2
`define PMTX_EV_ELIDED_CODE   8'hC8
`define PMTX_EV_RESTR_CODE    8'hC9
`define PMTX_EV_ABORT_MASK    8'h04
`define PMTX_AI_ELIDED        32
`define PMTX_AI_RESTR         33
`define PMTX_AI_INSTR         34
`define PMTX_AI_NONINSTR      35
`define PMTX_AI_RETRY         36
`define PMTX_AI_CONFLICT      37
`define PMTX_AI_CAP_WR        38
`define PMTX_AI_CAP_RD        39
`define PMTX_ZERO64           64'h0000_0000_0000_0000
`endif

// ### rtl/pmtx_pkg.sv
// Purpose: types for the performance monitor transactional extensions
// Assumes: nothing
// Notes:   one-hot record writer states
package pmtx_pkg;
	typedef enum logic [3:0] {
		PMTX_IDLE  = 4'h1,
		PMTX_W_NIP = 4'h2,
		PMTX_W_TIP = 4'h4,
		PMTX_W_AI  = 4'h8
	} pmtx_state_t;
endpackage

// ### rtl/pmtx_sel_mem.sv
// Purpose: storage for the per-counter selector registers
// Assumes: one write port, one registered read port
// Notes:   read data lag the address by one cycle
`timescale 1ns/1ps
`default_nettype none
module pmtx_sel_mem #(
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic          clk_sys_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [63:0]   wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output var  logic [63:0]   rdata_o
);
	logic [63:0] mem [DEPTH];

	always_ff @(posedge clk_sys_i) begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
		rdata_o <= mem[raddr_i];
	end
endmodule // pmtx_sel_mem
`default_nettype wire

// ### rtl/pmtx_core.sv
// Purpose: transactional filters, offcore match and sample record writer
// Assumes: selector writes arrive as register strobes; record written
//          as three words on rec_we_o
// Notes:   counters are 48 bit; checkpoint is kept for counter two
//
// Operation
// - record B0H holds triggering instruction pointer
// - record 08H holds next instruction pointer
// - offcore selector: request, supplier, snoop fields
// - bits 0-2 match demand and L1 reads
// - bits 4-6 match second-level prefetch reads
// - bit 15 matches any other interconnect request
// - in-transaction filter counts only inside regions
// - checkpoint filter drops aborted-region events
// - abort restores checkpointed counter to pre-region value
// - no filters: count aborted and committed runs
// - sample inside region aborts region first
// - abort events support precise sampling
// - pending sample inside region forces abort
// - abort case: 08H, B0H and B8H all valid
// - pointer and abort info always filled
// - abort case 08H holds restart address
// - abort info cycles, elided, restricted flags
// - abort info instruction, unrelated, retry flags
// - abort info conflict, write, read capacity
// - precise counter overflow starts a record
`timescale 1ns/1ps
`default_nettype none
`include "pmtx_consts.svh"
module pmtx_core
	import pmtx_pkg::*;
#(
	parameter int NCNT = 4,
	parameter int CW   = 48
) (
	input  wire logic                    clk_sys_i,
	input  wire logic                    reset_i,
	input  wire logic                    sel_we_i,
	input  wire logic                    sel_is_offcore_i,
	input  wire logic [$clog2(NCNT)-1:0] sel_idx_i,
	input  wire logic [63:0]             sel_wdata_i,
	input  wire logic [$clog2(NCNT)-1:0] sel_ridx_i,
	input  wire logic [NCNT-1:0]         precise_en_i,
	input  wire logic [NCNT-1:0]         event_i,
	input  wire logic [15:0]             req_type_i,
	input  wire logic                    req_valid_i,
	input  wire logic                    tx_active_i,
	input  wire logic                    tx_commit_i,
	input  wire logic                    tx_abort_i,
	input  wire logic                    tx_elided_i,
	input  wire logic [5:0]              abort_cause_i,
	input  wire logic [63:0]             retire_ip_i,
	input  wire logic [63:0]             next_ip_i,
	input  wire logic [63:0]             restart_ip_i,
	output var  logic [63:0]             sel_rdata_o,
	output var  logic [63:0]             offcore_rdata_o,
	output var  logic [NCNT*CW-1:0]      count_o,
	output var  logic                    offcore_hit_o,
	output var  logic                    force_abort_o,
	output var  logic                    rec_we_o,
	output var  logic [7:0]              rec_off_o,
	output var  logic [63:0]             rec_data_o
);
	localparam int IW = $clog2(NCNT);

	// -------------------------------------------------------------
	// offcore request matching
	// -------------------------------------------------------------
	logic [63:0] offcore_sel, next_offcore_sel;
	logic        next_offcore_hit;

	function automatic logic rt_match(input logic [15:0] sel,
		input logic [15:0] req);
		rt_match = |(sel & req & `PMTX_RT_MASK);
	endfunction

	always_comb begin
		next_offcore_sel = offcore_sel;
		if (sel_we_i && sel_is_offcore_i)
			next_offcore_sel = sel_wdata_i & `PMTX_SEL_MASK;
		next_offcore_hit = req_valid_i && rt_match(offcore_sel[15:0], req_type_i);
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			offcore_sel   <= `PMTX_ZERO64;
			offcore_hit_o <= 1'b0;
		end else begin
			offcore_sel   <= next_offcore_sel;
			offcore_hit_o <= next_offcore_hit;
		end
	end
	assign offcore_rdata_o = offcore_sel;

	// -------------------------------------------------------------
	// selectors and filters
	// -------------------------------------------------------------
	logic [NCNT-1:0] in_tx_f, cp_f, next_in_tx_f, next_cp_f;

	pmtx_sel_mem #(.DEPTH(NCNT), .AW(IW)) u_mem (
		.clk_sys_i (clk_sys_i),
		.we_i      (sel_we_i && !sel_is_offcore_i),
		.waddr_i   (sel_idx_i),
		.wdata_i   (sel_wdata_i),
		.raddr_i   (sel_ridx_i),
		.rdata_o   (sel_rdata_o)
	);

	always_comb begin
		next_in_tx_f = in_tx_f;
		next_cp_f    = cp_f;
		if (sel_we_i && !sel_is_offcore_i) begin
			next_in_tx_f[sel_idx_i] = sel_wdata_i[`PMTX_EVS_IN_TX];
			// the filter exists only on counter two; elsewhere the bit is ignored
			next_cp_f[sel_idx_i] = sel_wdata_i[`PMTX_EVS_CP] &&
				(sel_idx_i == IW'(`PMTX_EVS_CP_INDEX));
		end
	end

	// -------------------------------------------------------------
	// counters with checkpoint
	// -------------------------------------------------------------
	logic [CW-1:0]   cnt [NCNT], next_cnt [NCNT];
	logic [CW-1:0]   ckpt [NCNT], next_ckpt [NCNT];
	logic            tx_prev, next_tx_prev;
	logic [NCNT-1:0] ovf;

	always_comb begin
		next_tx_prev = tx_active_i;
		for (int i = 0; i < NCNT; i++) begin
			next_cnt[i]  = cnt[i];
			next_ckpt[i] = ckpt[i];
			ovf[i]       = 1'b0;
			if (tx_active_i && !tx_prev)
				next_ckpt[i] = cnt[i];
			// in-tx filter drops outside events; no filter counts all
			if (event_i[i] && (!in_tx_f[i] || tx_active_i)) begin
				next_cnt[i] = cnt[i] + CW'(1);
				ovf[i]      = &cnt[i];
			end
			if (tx_abort_i && cp_f[i]) begin
				next_cnt[i] = ckpt[i];
				ovf[i]      = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			in_tx_f <= '0;
			cp_f    <= '0;
			tx_prev <= 1'b0;
			for (int i = 0; i < NCNT; i++) begin
				cnt[i]  <= '0;
				ckpt[i] <= '0;
			end
		end else begin
			in_tx_f <= next_in_tx_f;
			cp_f    <= next_cp_f;
			tx_prev <= next_tx_prev;
			for (int i = 0; i < NCNT; i++) begin
				cnt[i]  <= next_cnt[i];
				ckpt[i] <= next_ckpt[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NCNT; i++)
			count_o[i*CW +: CW] = cnt[i];
	end

	// -------------------------------------------------------------
	// precise sample record writer
	// -------------------------------------------------------------
	pmtx_state_t state, next_state;
	logic        pend, next_pend;
	logic        abort_case, next_abort_case;
	logic [31:0] tx_cycles, next_tx_cycles, last_cycles, next_last_cycles;
	logic [63:0] ai, next_ai, tip, next_tip, nip, next_nip;
	logic        next_force_abort, next_rec_we;
	logic [7:0]  next_rec_off;
	logic [63:0] next_rec_data;
	logic        trig;

	always_comb begin
		trig             = |(ovf & precise_en_i);
		next_pend        = pend;
		next_abort_case  = abort_case;
		next_state       = state;
		next_ai          = ai;
		next_tip         = tip;
		next_nip         = nip;
		next_force_abort = 1'b0;
		next_rec_we      = 1'b0;
		next_rec_off     = rec_off_o;
		next_rec_data    = rec_data_o;
		next_tx_cycles   = tx_active_i ? tx_cycles + 32'h0000_0001 : 32'h0000_0000;
		next_last_cycles = last_cycles;
		if ((tx_commit_i || tx_abort_i) && tx_active_i)
			next_last_cycles = tx_cycles + 32'h0000_0001;
		if (trig && !pend) begin
			next_pend = 1'b1;
			next_tip  = retire_ip_i;
			next_nip  = next_ip_i;
			next_abort_case = 1'b0;
		end
		// a sample pending inside a region aborts it before processing
		if ((pend || trig) && tx_active_i && !tx_abort_i)
			next_force_abort = 1'b1;
		if (tx_abort_i && (pend || trig)) begin
			next_abort_case = 1'b1;
			next_nip = restart_ip_i;
			next_ai = {24'h00_0000, abort_cause_i, !tx_elided_i, tx_elided_i,
				(tx_active_i ? tx_cycles + 32'h0000_0001 : last_cycles)};
		end else if (trig && !pend) begin
			next_ai = {30'h0000_0000, 2'b00, next_last_cycles};
		end
		unique case (state)
			PMTX_IDLE: begin
				if (pend && !tx_active_i)
					next_state = PMTX_W_NIP;
			end
			PMTX_W_NIP: begin
				next_rec_we   = 1'b1;
				next_rec_off  = `PMTX_OFF_NEXT_IP;
				next_rec_data = nip;
				next_state    = PMTX_W_TIP;
			end
			PMTX_W_TIP: begin
				next_rec_we   = 1'b1;
				next_rec_off  = `PMTX_OFF_TRIG_IP;
				next_rec_data = tip;
				next_state    = PMTX_W_AI;
			end
			PMTX_W_AI: begin
				next_rec_we   = 1'b1;
				next_rec_off  = `PMTX_OFF_ABORT_INFO;
				next_rec_data = ai;
				next_pend     = 1'b0;
				next_state    = PMTX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state         <= PMTX_IDLE;
			pend          <= 1'b0;
			abort_case    <= 1'b0;
			ai            <= `PMTX_ZERO64;
			tip           <= `PMTX_ZERO64;
			nip           <= `PMTX_ZERO64;
			tx_cycles     <= 32'h0000_0000;
			last_cycles   <= 32'h0000_0000;
			force_abort_o <= 1'b0;
			rec_we_o      <= 1'b0;
			rec_off_o     <= 8'h00;
			rec_data_o    <= `PMTX_ZERO64;
		end else begin
			state         <= next_state;
			pend          <= next_pend;
			abort_case    <= next_abort_case;
			ai            <= next_ai;
			tip           <= next_tip;
			nip           <= next_nip;
			tx_cycles     <= next_tx_cycles;
			last_cycles   <= next_last_cycles;
			force_abort_o <= next_force_abort;
			rec_we_o      <= next_rec_we;
			rec_off_o     <= next_rec_off;
			rec_data_o    <= next_rec_data;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	sequence s_write3;
		rec_we_o ##1 rec_we_o ##1 rec_we_o;
	endsequence

	rec_order_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(rec_we_o) |-> rec_off_o == `PMTX_OFF_NEXT_IP ##1
		rec_off_o == `PMTX_OFF_TRIG_IP ##1 rec_off_o == `PMTX_OFF_ABORT_INFO)
		else $error("record words out of order");
	rec_burst_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$rose(rec_we_o) |-> s_write3 ##1 !rec_we_o)
		else $error("record burst not three words");
	ovf_start_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		trig && !pend && !tx_active_i |-> ##[2:3] rec_we_o)
		else $error("overflow did not start a record");
	tx_abort_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		pend && tx_active_i && !tx_abort_i |=> force_abort_o)
		else $error("pending sample did not abort region");
	no_rec_tx_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state == PMTX_IDLE && tx_active_i |=> state == PMTX_IDLE)
		else $error("record started inside a region");
	cp_only_two_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(cp_f & ~(NCNT'(1) << `PMTX_EVS_CP_INDEX)) == '0)
		else $error("checkpoint filter off counter two");
	cp_restore_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		tx_abort_i && cp_f[`PMTX_EVS_CP_INDEX] |=>
		cnt[`PMTX_EVS_CP_INDEX] == $past(ckpt[`PMTX_EVS_CP_INDEX]))
		else $error("counter not restored on abort");
	in_tx_drop_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		in_tx_f[0] && !tx_active_i && !tx_abort_i |=> $stable(cnt[0]))
		else $error("outside event counted");
	ai_resv_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ai[63:40] == 24'h00_0000 && offcore_sel[14:7] == 8'h00)
		else $error("reserved bits set");
	abort_kind_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		state == PMTX_W_AI |=>
		(rec_data_o[33:32] != 2'b00) == $past(abort_case))
		else $error("abort kind bits disagree with record case");
endmodule // pmtx_core
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: self-checking bench for the transactional monitor core
// Assumes: counters shrunk to 4 bits so a wrap takes 16 events
// Notes:   record words are taken one cycle apart, off the clock edge
`timescale 1ns/1ps
`default_nettype none
`include "pmtx_consts.svh"
module tb_top;
	import pmtx_pkg::*;
	localparam int          NCNT       = 4;
	localparam int          CW         = 4;
	localparam logic [63:0] NIP        = 64'h0000_1000_0000_0040;
	localparam logic [63:0] TIP        = 64'h0000_1000_0000_0020;
	localparam logic [63:0] RIP        = 64'h0000_1000_0000_0080;
	localparam logic [15:0] RTYPE_MASK = `PMTX_RT_MASK;
	logic                 clk_sys_i        = 1'b0;
	logic                 reset_i          = 1'b1;
	logic                 sel_we_i         = 1'b0;
	logic                 sel_is_offcore_i = 1'b0;
	logic [1:0]           sel_idx_i        = 2'h0;
	logic [63:0]          sel_wdata_i      = 64'h0;
	logic [1:0]           sel_ridx_i       = 2'h0;
	logic [NCNT-1:0]      precise_en_i     = 4'h0;
	logic [NCNT-1:0]      event_i          = 4'h0;
	logic [15:0]          req_type_i       = 16'h0;
	logic                 req_valid_i      = 1'b0;
	logic                 tx_active_i      = 1'b0;
	logic                 tx_commit_i      = 1'b0;
	logic                 tx_abort_i       = 1'b0;
	logic                 tx_elided_i      = 1'b0;
	logic [5:0]           abort_cause_i    = 6'h0;
	logic [63:0]          sel_rdata_o;
	logic [63:0]          offcore_rdata_o;
	logic [NCNT*CW-1:0]   count_o;
	logic                 offcore_hit_o;
	logic                 force_abort_o;
	logic                 rec_we_o;
	logic [7:0]           rec_off_o;
	logic [63:0]          rec_data_o;
	int                   n_mismatch       = 0;
	int                   n_checks         = 0;
	int                   w;

	always #4 clk_sys_i = ~clk_sys_i;

	pmtx_core #(.NCNT(NCNT), .CW(CW)) u_pmtx_core (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sel_we_i(sel_we_i),
		.sel_is_offcore_i(sel_is_offcore_i), .sel_idx_i(sel_idx_i),
		.sel_wdata_i(sel_wdata_i), .sel_ridx_i(sel_ridx_i),
		.precise_en_i(precise_en_i), .event_i(event_i),
		.req_type_i(req_type_i), .req_valid_i(req_valid_i),
		.tx_active_i(tx_active_i), .tx_commit_i(tx_commit_i),
		.tx_abort_i(tx_abort_i), .tx_elided_i(tx_elided_i),
		.abort_cause_i(abort_cause_i), .retire_ip_i(TIP),
		.next_ip_i(NIP), .restart_ip_i(RIP), .sel_rdata_o(sel_rdata_o),
		.offcore_rdata_o(offcore_rdata_o), .count_o(count_o),
		.offcore_hit_o(offcore_hit_o), .force_abort_o(force_abort_o),
		.rec_we_o(rec_we_o), .rec_off_o(rec_off_o), .rec_data_o(rec_data_o)
	);

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic off, input logic [1:0] i,
			input logic [63:0] d);
		@(posedge clk_sys_i);
		sel_we_i <= 1'b1;
		sel_is_offcore_i <= off;
		sel_idx_i <= i;
		sel_wdata_i <= d;
		@(posedge clk_sys_i);
		sel_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] i, input logic [63:0] e);
		@(posedge clk_sys_i);
		sel_ridx_i <= i;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(sel_rdata_o, e);
	endtask

	// one event per pulse, with a gap so every pulse is a separate count
	task automatic ev(input logic [3:0] m, input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			event_i <= m;
			@(posedge clk_sys_i);
			event_i <= 4'h0;
		end
	endtask

	task automatic region(input logic ab, input int n);
		@(posedge clk_sys_i);
		tx_active_i <= 1'b1;
		ev(4'hF, n);
		@(posedge clk_sys_i);
		tx_commit_i <= !ab;
		tx_abort_i <= ab;
		@(posedge clk_sys_i);
		tx_commit_i <= 1'b0;
		tx_abort_i <= 1'b0;
		tx_active_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
	endtask

	task automatic hits(input logic [63:0] sel);
		wr(1'b1, 2'h0, sel);
		for (int b = 0; b < 16; b++) begin
			@(posedge clk_sys_i);
			req_type_i <= 16'h0001 << b;
			req_valid_i <= 1'b1;
			@(posedge clk_sys_i);
			req_valid_i <= 1'b0;
			#1;
			chk(64'(offcore_hit_o), 64'(sel[b] & RTYPE_MASK[b]));
		end
		chk(offcore_rdata_o, sel & `PMTX_SEL_MASK);
	endtask

	// waits for the record, then takes its three words one cycle apart
	task automatic get_rec(input logic [63:0] nip, input logic [7:0] ai_hi,
			input logic [31:0] cyc, output int n);
		n = 0;
		// step off the edge so a word launched on it is not missed
		#1;
		while (rec_we_o !== 1'b1) begin
			if (n == 10) begin
				n_mismatch++;
				end_sim();
			end
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		chk(64'(rec_off_o), 64'(`PMTX_OFF_NEXT_IP));
		chk(rec_data_o, nip);
		@(posedge clk_sys_i);
		#1;
		chk({rec_we_o, 55'h0, rec_off_o}, {1'b1, 55'h0, `PMTX_OFF_TRIG_IP});
		chk(rec_data_o, TIP);
		@(posedge clk_sys_i);
		#1;
		chk({rec_we_o, 55'h0, rec_off_o}, {1'b1, 55'h0, `PMTX_OFF_ABORT_INFO});
		chk({32'h0, rec_data_o[63:32]}, {56'h0, ai_hi});
		chk(64'(rec_data_o[31:0]), 64'(cyc));
		@(posedge clk_sys_i);
		#1;
		chk(64'(rec_we_o), 64'h0);
	endtask

	// wraps counter three inside a region, holds it, then aborts it
	task automatic tx_rec(input logic el, input logic [5:0] cause, input int n,
			input logic [7:0] hi, input logic [31:0] cyc);
		@(posedge clk_sys_i);
		precise_en_i <= 4'h8;
		tx_active_i <= 1'b1;
		tx_elided_i <= el;
		abort_cause_i <= cause;
		ev(4'h8, n);
		#1;
		chk(64'(force_abort_o), 64'h1);
		repeat (4) @(posedge clk_sys_i);
		#1;
		chk({62'h0, force_abort_o, rec_we_o}, 64'h2);
		@(posedge clk_sys_i);
		tx_abort_i <= 1'b1;
		@(posedge clk_sys_i);
		tx_abort_i <= 1'b0;
		tx_active_i <= 1'b0;
		get_rec(RIP, hi, cyc, w);
		chk(64'(force_abort_o), 64'h0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk(64'(count_o), 64'h0);
		chk({61'h0, rec_we_o, force_abort_o, offcore_hit_o}, 64'h0);
		hits(64'hFFFF_FFFF_FFFF_FFFF);
		hits(64'h0000_0000_0000_0020);
		// filters are set as on a processor that reports transaction support
		wr(1'b0, 2'h0, 64'h0000_0001_0000_00C8);
		wr(1'b0, 2'h1, 64'h0000_0000_0000_00C8);
		wr(1'b0, 2'h2, 64'h0000_0002_0000_00C9);
		wr(1'b0, 2'h3, 64'h0000_0000_0000_00C9);
		rd(2'h2, 64'h0000_0002_0000_00C9);
		rd(2'h3, 64'h0000_0000_0000_00C9);
		ev(4'hF, 3);
		#1;
		chk(64'(count_o), 64'h3330);
		region(1'b0, 2);
		chk(64'(count_o), 64'h5552);
		region(1'b1, 2);
		chk(64'(count_o), 64'h7574);
		// precise record outside any region; last region lasted 6 cycles
		@(posedge clk_sys_i);
		precise_en_i <= 4'h2;
		ev(4'h2, 9);
		get_rec(NIP, 8'h00, 32'h0000_0006, w);
		chk(64'(w), 64'h2);
		chk(64'(count_o), 64'h7504);
		// wraps inside a restricted, then an elided region
		tx_rec(1'b0, 6'h25, 9, 8'h96, 32'h0000_0018);
		tx_rec(1'b1, 6'h0A, 16, 8'h29, 32'h0000_0026);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
